// [src/aafl_cfg.svh]
// Register offsets, field positions, reset values and timing counts of the align and fault block
`ifndef AAFL_CFG_SVH
`define AAFL_CFG_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define AAFL_OFS_STATUS   12'h000
`define AAFL_OFS_INTERFACE_MODE_REGISTER   12'h004
`define AAFL_OFS_PINCFG   12'h008
`define AAFL_OFS_CHEN     12'h00C
`define AAFL_OFS_CRCCHK   12'h010
`define AAFL_OFS_RESULT   12'h014
`define AAFL_OFS_CONV     12'h018
`define AAFL_OFS_REGSUM   12'h01C

// ****************************************************************
// Field positions
// ****************************************************************
`define AAFL_ST_RDY_N     7
`define AAFL_ST_CONV_ERR  6
`define AAFL_ST_CRC_ERR   5
`define AAFL_ST_REG_ERR   4
`define AAFL_IF_ALT       12
`define AAFL_IF_APPEND    6
`define AAFL_IF_MONITOR   5
`define AAFL_PC_ALIGN_EN  11
`define AAFL_PC_FPF_HI    10
`define AAFL_PC_FPF_LO    9
`define AAFL_PC_FPDATA    8

// ****************************************************************
// Reset values
// ****************************************************************
`define AAFL_RST_INTERFACE_MODE_REGISTER   16'h0000
`define AAFL_RST_PINCFG   16'h0800
`define AAFL_RST_CHEN     16'h0001

// ****************************************************************
// Timing and CRC
// ****************************************************************
`define AAFL_SETTLE_NS    1000
`define AAFL_CLK_NS       10
`define AAFL_SETTLE_CYC   ((`AAFL_SETTLE_NS + `AAFL_CLK_NS - 1) / `AAFL_CLK_NS)
`define AAFL_CRC_POLY     8'h07

`endif

// [src/aafl_pkg.sv]
// Types shared by the align and fault block
package aafl_pkg;

  // Fault pin function codes
  typedef enum logic [1:0] {
    AAFL_FP_OFF = 2'h0,
    AAFL_FP_IN  = 2'h1,
    AAFL_FP_OUT = 2'h2,
    AAFL_FP_GPO = 2'h3
  } aafl_fpf_t;

  // Converter sequencing states
  typedef enum logic [3:0] {
    AAFL_S_HELD = 4'h1,
    AAFL_S_WAIT = 4'h2,
    AAFL_S_CONV = 4'h4,
    AAFL_S_IDLE = 4'h8
  } aafl_state_t;

endpackage : aafl_pkg

// [src/aafl_sync2.sv]
// Two-stage synchroniser for a pin input
`timescale 1ns/1ns
`default_nettype none
module aafl_sync2 (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin and result
  input  wire logic pin,
  output var  logic level
);

  typedef struct packed {
    logic meta;
    logic sync;
  } aafl_sync_t;

  aafl_sync_t r;
  aafl_sync_t next_r;

  // First stage feeds only the second
  always_comb begin
    next_r.meta = pin;
    next_r.sync = r.meta;
  end

  // Idle high, like the pins at rest
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= 2'h3;
    end else begin
      r <= next_r;
    end
  end

  assign level = r.sync;

endmodule : aafl_sync2
`default_nettype wire

// [src/aafl_crc8.sv]
// Combinational 8-bit CRC over a 32-bit word, x^8 + x^2 + x + 1
`timescale 1ns/1ns
`default_nettype none
`include "aafl_cfg.svh"
module aafl_crc8 (
  // Data in, check value out
  input  wire logic [31:0] data,
  output var  logic [7:0]  crc
);

  // Bitwise long division, MSB first, zero start value
  always_comb begin
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      if (c[7] ^ data[i]) begin
        c = {c[6:0], 1'b0} ^ `AAFL_CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    crc = c;
  end

endmodule : aafl_crc8
`default_nettype wire

// [src/aafl_top.sv]
// Conversion alignment and fault reporting logic with an APB register slave
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "aafl_cfg.svh"
module aafl_top #(
  parameter int CHANNELS   = 16,
  parameter int SETTLE_CYC = `AAFL_SETTLE_CYC
) (
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Alignment pin, active low
  input  wire logic        align_n,
  // Fault pin, three signals
  input  wire logic        fault_n_in,
  output var  logic        fault_n_out,
  output var  logic        fault_n_oe,
  // Converter side
  output var  logic        filter_reset,
  output var  logic        data_ready_n,
  output var  logic [3:0]  active_channel,
  output var  logic [31:0] result_word
);
  import aafl_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [15:0]  interface_mode_register;
    logic [15:0]  pincfg;
    logic [15:0]  chen;
    logic [23:0]  data;
    logic [1:0]   vin;           // Stored over- and undervoltage request
    logic         conv_err;
    logic         crc_err;
    logic         reg_err;
    logic [7:0]   regsum;
    aafl_state_t  st;
    logic [3:0]   chan;
    logic [3:0]   res_chan;
    logic [15:0]  cnt;
    logic         align_q;
    logic         rdy_n;
    logic         freset;
    logic [31:0]  rdata;
    logic         ready;
    logic         slverr;
    logic         fp_out;
    logic         fp_oe;
    logic [31:0]  result;
  } aafl_regs_t;

  aafl_regs_t r;
  aafl_regs_t next_r;

  logic        align_lvl, fault_lvl;
  logic [7:0]  crc_calc, sum_now;

  // ****************************************************************
  // Pin synchronisers and CRC engine
  // ****************************************************************
  // pins synchronised
  aafl_sync2 u_sync_align (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (align_n),
    .level   (align_lvl)
  );

  aafl_sync2 u_sync_fault (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (fault_n_in),
    .level   (fault_lvl)
  );

  // check over command byte and 16-bit data
  aafl_crc8 u_crc (
    .data (pwdata),
    .crc  (crc_calc)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Lowest enabled channel at or above start, wrapping
  function automatic logic [3:0] next_chan(input logic [15:0] en, input logic [3:0] start);
    logic [3:0] pick;
    logic       found;
    logic [3:0] idx;
    pick  = start;
    found = 1'b0;
    for (int k = 0; k < 16; k++) begin
      idx = 4'(start + 4'(k));
      if (!found && en[idx]) begin
        pick  = idx;
        found = 1'b1;
      end
    end
    return pick;
  endfunction : next_chan

  // checksum covers only pin config and channel enables
  assign sum_now = r.pincfg[15:8] ^ r.pincfg[7:0] ^ r.chen[15:8] ^ r.chen[7:0];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic        wr, rd;
    logic        fall, rise;
    logic        out_of_range, done;
    logic [1:0]  fpf;
    logic [7:0]  status;
    next_r = r;
    wr   = psel && penable && pwrite && !r.ready;
    rd   = psel && penable && !pwrite && !r.ready;
    fall = r.align_q && !align_lvl;
    rise = !r.align_q && align_lvl;
    fpf  = r.pincfg[`AAFL_PC_FPF_HI:`AAFL_PC_FPF_LO];
    next_r.align_q = align_lvl;
    done = 1'b0;
    out_of_range = 1'b0;
    next_r.ready  = psel && penable && !r.ready;
    next_r.slverr = 1'b0;
    next_r.rdata  = 32'h0000_0000;
    status = {r.rdy_n, r.conv_err, r.crc_err, r.reg_err, r.res_chan};

    // Sequencer and conversion timing
    case (r.st)
      AAFL_S_HELD: begin
        // leave reset one clock after the rise
        if (align_lvl) begin
          next_r.freset = 1'b0;
          next_r.st     = AAFL_S_CONV;
          next_r.cnt    = 16'h0000;
        end
      end
      AAFL_S_WAIT: begin
        // hold until the pin is high again
        if (align_lvl) begin
          next_r.st  = AAFL_S_CONV;
          next_r.cnt = 16'h0000;
        end
      end
      AAFL_S_CONV: begin
        if (r.cnt >= 16'(SETTLE_CYC - 1)) begin
          done = 1'b1;
        end else begin
          next_r.cnt = r.cnt + 16'h0001;
        end
      end
      AAFL_S_IDLE: begin
        // single channel rising edge starts one conversion
        if (rise) begin
          next_r.st  = AAFL_S_CONV;
          next_r.cnt = 16'h0000;
        end
      end
      default: next_r.st = AAFL_S_HELD;
    endcase

    // result, ready and channel tag at end of conversion
    if (done) begin
      next_r.rdy_n    = 1'b0;
      next_r.res_chan = r.chan;
      next_r.cnt      = 16'h0000;
      // saturate on a stored over- or undervoltage, overvoltage first
      next_r.data  = r.vin[1] ? 24'hFFFFFF : (r.vin[0] ? 24'h000000 : 24'h800000);
      out_of_range = |r.vin;
      next_r.chan = next_chan(r.chen, 4'(r.chan + 4'h1));
      if (r.interface_mode_register[`AAFL_IF_ALT] && !align_lvl) begin
        // finish, advance, then wait for high
        next_r.st = AAFL_S_WAIT;
      end else if ((r.chen & (r.chen - 16'h0001)) == 16'h0000 && r.pincfg[`AAFL_PC_ALIGN_EN]) begin
        // single channel idles until the next start edge
        next_r.st = AAFL_S_IDLE;
      end
    end

    // alignment only when enabled, configuration kept
    if (r.pincfg[`AAFL_PC_ALIGN_EN] && !r.interface_mode_register[`AAFL_IF_ALT]) begin
      // falling edge holds modulator and filter in reset
      if (fall || (!align_lvl && r.st == AAFL_S_HELD)) begin
        next_r.freset = 1'b1;
        next_r.st     = AAFL_S_HELD;
        next_r.cnt    = 16'h0000;
        next_r.chan   = next_chan(r.chen, 4'h0);
      end
    end

    // conversion fault tracks the condition, not reads
    // external fault input ORed in when configured
    next_r.conv_err = (done ? out_of_range : r.conv_err && (r.data == 24'hFFFFFF || r.data == 24'h000000))
                      || (fpf == 2'(AAFL_FP_IN) && !fault_lvl);
    if (fpf == 2'(AAFL_FP_IN)) begin
      next_r.pincfg[`AAFL_PC_FPDATA] = fault_lvl;
    end

    // any change of the XOR sum of the monitored bytes sets the flag
    if (r.interface_mode_register[`AAFL_IF_MONITOR]) begin
      if (sum_now != r.regsum) begin
        next_r.reg_err = 1'b1;
      end
    end else begin
      next_r.regsum = sum_now;
      next_r.reg_err = 1'b0;
    end

    // APB reads; data read leaves faults alone
    if (rd) begin
      case (paddr)
        `AAFL_OFS_STATUS: begin
          next_r.rdata = {24'h000000, status};
          // status read clears only the CRC flag, a new mismatch wins below
          next_r.crc_err = 1'b0;
        end
        `AAFL_OFS_INTERFACE_MODE_REGISTER: next_r.rdata = {16'h0000, r.interface_mode_register};
        `AAFL_OFS_PINCFG: next_r.rdata = {16'h0000, r.pincfg};
        `AAFL_OFS_CHEN:   next_r.rdata = {16'h0000, r.chen};
        `AAFL_OFS_RESULT: begin
          next_r.rdata = {8'h00, r.data};
          next_r.rdy_n = 1'b1;
        end
        `AAFL_OFS_REGSUM: next_r.rdata = {24'h000000, r.regsum};
        default: next_r.slverr = 1'b1;
      endcase
    end

    // APB writes
    if (wr) begin
      case (paddr)
        `AAFL_OFS_INTERFACE_MODE_REGISTER: next_r.interface_mode_register = pwdata[15:0];
        `AAFL_OFS_PINCFG: next_r.pincfg = pwdata[15:0];
        `AAFL_OFS_CHEN: begin
          next_r.chen = pwdata[15:0];
          next_r.chan = next_chan(pwdata[15:0], 4'h0);
        end
        // word carries data and check byte
        `AAFL_OFS_CRCCHK: begin
          if (crc_calc != 8'h00) begin
            next_r.crc_err = 1'b1;
          end
        end
        `AAFL_OFS_CONV: next_r.vin = pwdata[31:30];  // Bus data is only valid inside the transfer
        default: next_r.slverr = 1'b1;
      endcase
    end

    // status appended; new values, so the word moves with ready
    status = {next_r.rdy_n, next_r.conv_err, next_r.crc_err, next_r.reg_err, next_r.res_chan};
    next_r.result = r.interface_mode_register[`AAFL_IF_APPEND] ? {next_r.data, status} : {8'h00, next_r.data};

    // open-drain OR of faults; off or general output
    case (fpf)
      2'(AAFL_FP_OUT): begin
        next_r.fp_out = 1'b0;
        next_r.fp_oe  = next_r.conv_err | next_r.crc_err | next_r.reg_err;
      end
      2'(AAFL_FP_GPO): begin
        next_r.fp_out = r.pincfg[`AAFL_PC_FPDATA];
        next_r.fp_oe  = 1'b1;
      end
      default: begin
        next_r.fp_out = 1'b1;
        next_r.fp_oe  = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r        <= '0;
      r.interface_mode_register <= `AAFL_RST_INTERFACE_MODE_REGISTER;
      r.pincfg <= `AAFL_RST_PINCFG;
      r.chen   <= `AAFL_RST_CHEN;
      r.st     <= AAFL_S_CONV;
      r.align_q <= 1'b1;
      r.rdy_n  <= 1'b1;
      r.fp_out <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from flip-flops
  assign prdata         = r.rdata;
  assign pready         = r.ready;
  assign pslverr        = r.slverr;
  assign fault_n_out    = r.fp_out;
  assign fault_n_oe     = r.fp_oe;
  assign filter_reset   = r.freset;
  assign data_ready_n   = r.rdy_n;
  assign active_channel = r.chan;
  assign result_word    = r.result;

endmodule : aafl_top
`default_nettype wire

// [testbench/aafl_top_chk.sv]
// Port-level checker of the APB answer timing and the alignment behaviour
`timescale 1ns/1ns
`default_nettype none
module aafl_top_chk #(
  parameter int CHANNELS   = 16,
  parameter int SETTLE_CYC = 100
) (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // APB
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // Converter side
  input wire logic       align_n,
  input wire logic       filter_reset,
  input wire logic       data_ready_n,
  input wire logic [3:0] active_channel
);
  // ****************************************************************
  // Assertions, all in the one clock domain
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // One wait state, then a single-cycle answer
  ready_one_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late after access phase");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // Reset entry only after the pin was low three clocks before
  reset_entry_a: assert property ($rose(filter_reset) |-> $past(!align_n, 3))
    else $error("filter reset rose without a low pin");
  reset_hold_a: assert property (filter_reset && $past(!align_n, 2) |=> filter_reset)
    else $error("filter reset dropped while pin low");
  reset_exit_a: assert property ($fell(filter_reset) |-> $past(align_n, 3))
    else $error("filter reset fell without a high pin");
  settle_min_a: assert property ($fell(filter_reset) |-> (!$fell(data_ready_n)) [*3])
    else $error("result came before settling");
  ready_not_reset_a: assert property ($fell(data_ready_n) |-> !$past(filter_reset))
    else $error("result completed out of filter reset");
  chan_hold_a: assert property (filter_reset && $past(filter_reset) |-> $stable(active_channel))
    else $error("channel moved while held in reset");
endmodule : aafl_top_chk

bind aafl_top aafl_top_chk #(.CHANNELS(CHANNELS), .SETTLE_CYC(SETTLE_CYC)) chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .align_n(align_n), .filter_reset(filter_reset),
  .data_ready_n(data_ready_n), .active_channel(active_channel)
);
`default_nettype wire

// [testbench/aafl_host.sv]
// Host model driving the alignment pin and an external part on the fault line
`timescale 1ns/1ns
`default_nettype none
module aafl_host (
  // Clock
  input  wire logic pclk,
  // Fault line
  input  wire logic fault_n_out,
  input  wire logic fault_n_oe,
  output var  logic fault_n_in,
  // Alignment pin
  output var  logic align_n
);
  logic ext_low;  // External part pulls the line low

  initial begin
    align_n = 1'b1;
    ext_low = 1'b0;
  end
  // Pull-up wins unless someone drives low
  always_comb begin
    fault_n_in = !(ext_low || (fault_n_oe && !fault_n_out));
  end
  // driven right after a rising edge
  task automatic pins(input logic al, input logic ext);
    @(posedge pclk);
    align_n <= al;
    ext_low <= ext;
  endtask : pins
  task automatic align_pulse(input int low_cyc);
    pins(1'b0, ext_low);
    repeat (low_cyc) @(posedge pclk);
    pins(1'b1, ext_low);
  endtask : align_pulse
endmodule : aafl_host
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench of the align and fault block
`timescale 1ns/1ns
`default_nettype none
`include "aafl_cfg.svh"
module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        align_n;
  logic        fault_n_in;
  logic        fault_n_out;
  logic        fault_n_oe;
  logic        filter_reset;
  logic        data_ready_n;
  logic [3:0]  active_channel;
  logic [31:0] result_word;
  logic [31:0] rd;
  logic        se;
  int          err_count = 0;
  int          num_checks = 0;

  // Short settling keeps the run brief
  aafl_top #(.SETTLE_CYC(4)) aafl_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .align_n(align_n), .fault_n_in(fault_n_in), .fault_n_out(fault_n_out),
    .fault_n_oe(fault_n_oe), .filter_reset(filter_reset), .data_ready_n(data_ready_n),
    .active_channel(active_channel), .result_word(result_word)
  );
  aafl_host aafl_host_i (
    .pclk(pclk), .fault_n_out(fault_n_out), .fault_n_oe(fault_n_oe),
    .fault_n_in(fault_n_in), .align_n(align_n)
  );
  // 100 MHz clock
  always #5 pclk = ~pclk;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer, pready sampled at the falling edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Look between edges: what stands here is what the next edge samples
    do begin
      @(negedge pclk);
      n++;
      if (n > 50) begin
        err_count++;
        end_sim();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask : rd_chk
  // Bounded wait on data ready (rdy=1) or filter reset (rdy=0)
  task automatic wait_lvl(input logic rdy, input logic lvl);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
      if (n > 300) begin
        err_count++;
        end_sim();
      end
    end while ((rdy ? data_ready_n : filter_reset) !== lvl);
  endtask : wait_lvl
  // Read clears data ready, then a start pulse and its result
  task automatic conv();
    apb(1'b0, `AAFL_OFS_RESULT, 32'h0);
    aafl_host_i.align_pulse(4);
    wait_lvl(1'b1, 1'b0);
  endtask : conv
  task automatic pcfg(input logic [31:0] v);
    apb(1'b1, `AAFL_OFS_PINCFG, v);
    repeat (2) @(negedge pclk);
  endtask : pcfg

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    rd_chk(`AAFL_OFS_PINCFG, 32'hFFFF_FFFF, 32'h0000_0800);
    rd_chk(`AAFL_OFS_CHEN, 32'hFFFF_FFFF, 32'h0000_0001);
    rd_chk(`AAFL_OFS_INTERFACE_MODE_REGISTER, 32'hFFFF_FFFF, 32'h0);
    apb(1'b0, 12'h0FC, 32'h0);
    chk(32'(se), 32'h1);
    apb(1'b1, `AAFL_OFS_STATUS, 32'hFF);
    chk(32'(se), 32'h1);
    $display("register test done");
  endtask : t_regs
  task automatic t_align();
    apb(1'b1, `AAFL_OFS_CHEN, 32'h6);
    aafl_host_i.pins(1'b0, 1'b0);
    wait_lvl(1'b0, 1'b1);
    repeat (3) @(negedge pclk);
    chk(32'(filter_reset), 32'h1);
    chk(32'(active_channel), 32'h1);
    rd_chk(`AAFL_OFS_PINCFG, 32'hFFFF, 32'h0800);
    apb(1'b0, `AAFL_OFS_RESULT, 32'h0);
    aafl_host_i.pins(1'b1, 1'b0);
    wait_lvl(1'b0, 1'b0);
    wait_lvl(1'b1, 1'b0);
    pcfg(32'h0);
    aafl_host_i.pins(1'b0, 1'b0);
    repeat (6) @(negedge pclk);
    chk(32'(filter_reset), 32'h0);
    aafl_host_i.pins(1'b1, 1'b0);
    pcfg(32'h0800);
    $display("align test done");
  endtask : t_align
  task automatic t_conv_fault();
    apb(1'b1, `AAFL_OFS_CHEN, 32'h1);
    apb(1'b1, `AAFL_OFS_CONV, 32'h8000_0000);
    conv();
    chk(result_word, 32'h00FF_FFFF);
    apb(1'b1, `AAFL_OFS_CONV, 32'h4000_0000);
    conv();
    chk(result_word, 32'h0);
    rd_chk(`AAFL_OFS_STATUS, 32'h40, 32'h40);
    apb(1'b1, `AAFL_OFS_CONV, 32'h0);
    conv();
    rd_chk(`AAFL_OFS_STATUS, 32'h40, 32'h0);
    $display("conversion fault test done");
  endtask : t_conv_fault
  task automatic t_crc();
    apb(1'b1, `AAFL_OFS_CRCCHK, 32'h6543_2187);
    rd_chk(`AAFL_OFS_STATUS, 32'h20, 32'h20);
    rd_chk(`AAFL_OFS_STATUS, 32'h20, 32'h0);
    apb(1'b1, `AAFL_OFS_CRCCHK, 32'h6543_2186);
    rd_chk(`AAFL_OFS_STATUS, 32'h20, 32'h0);
    $display("check value test done");
  endtask : t_crc
  task automatic t_monitor();
    apb(1'b1, `AAFL_OFS_INTERFACE_MODE_REGISTER, 32'h20);
    apb(1'b1, `AAFL_OFS_INTERFACE_MODE_REGISTER, 32'h60);
    rd_chk(`AAFL_OFS_STATUS, 32'h10, 32'h0);
    pcfg(32'h0C00);
    rd_chk(`AAFL_OFS_STATUS, 32'h10, 32'h10);
    chk(32'(fault_n_in), 32'h0);
    apb(1'b1, `AAFL_OFS_INTERFACE_MODE_REGISTER, 32'h0);
    rd_chk(`AAFL_OFS_STATUS, 32'h10, 32'h0);
    repeat (2) @(negedge pclk);
    chk(32'(fault_n_in), 32'h1);
    $display("monitor test done");
  endtask : t_monitor
  task automatic t_pin();
    pcfg(32'h0A00);
    aafl_host_i.pins(1'b1, 1'b1);
    repeat (4) @(negedge pclk);
    rd_chk(`AAFL_OFS_STATUS, 32'h40, 32'h40);
    rd_chk(`AAFL_OFS_PINCFG, 32'h100, 32'h0);
    aafl_host_i.pins(1'b1, 1'b0);
    repeat (4) @(negedge pclk);
    rd_chk(`AAFL_OFS_PINCFG, 32'h100, 32'h100);
    rd_chk(`AAFL_OFS_STATUS, 32'h40, 32'h0);
    pcfg(32'h0E00);
    chk(32'({fault_n_oe, fault_n_out}), 32'h2);
    pcfg(32'h0F00);
    chk(32'({fault_n_oe, fault_n_out}), 32'h3);
    pcfg(32'h0800);
    chk(32'(fault_n_oe), 32'h0);
    $display("fault pin test done");
  endtask : t_pin
  task automatic t_alt();
    logic [3:0] ch;
    apb(1'b1, `AAFL_OFS_CHEN, 32'h8);
    apb(1'b1, `AAFL_OFS_INTERFACE_MODE_REGISTER, 32'h40);
    conv();
    chk(result_word & 32'hF, 32'h3);
    apb(1'b1, `AAFL_OFS_CHEN, 32'h6);
    aafl_host_i.align_pulse(4);
    apb(1'b1, `AAFL_OFS_INTERFACE_MODE_REGISTER, 32'h1040);
    apb(1'b0, `AAFL_OFS_RESULT, 32'h0);
    aafl_host_i.pins(1'b0, 1'b0);
    wait_lvl(1'b1, 1'b0);
    repeat (12) @(negedge pclk);
    ch = result_word[3:0];
    chk(32'(active_channel), 32'(ch ^ 4'h3));
    repeat (12) @(negedge pclk);
    chk(32'(result_word[3:0]), 32'(ch));
    apb(1'b0, `AAFL_OFS_RESULT, 32'h0);
    aafl_host_i.pins(1'b1, 1'b0);
    wait_lvl(1'b1, 1'b0);
    chk(32'(result_word[3:0]), 32'(ch ^ 4'h3));
    apb(1'b1, `AAFL_OFS_INTERFACE_MODE_REGISTER, 32'h0);
    $display("alternate mode test done");
  endtask : t_alt

  // Reset for ten clocks, then every scenario in turn
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_align();
    t_conv_fault();
    t_crc();
    t_monitor();
    t_pin();
    t_alt();
    end_sim();
  end
endmodule : tb
`default_nettype wire
